//--- core/owrc_core.sv
// Purpose: control-pin logic of a boost regulator reference
// Assumes: 50 MHz clock, analog flags asynchronous
// Notes: reference output is in millivolts
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "owrc_map.svh"
module owrc_core import owrc_pkg::*; #(
  parameter int unsigned STEP_CYC = `OWRC_STEP_CYC,
  parameter int unsigned HALF_CYC = `OWRC_HALF_CYC,
  parameter int unsigned OFF_CYC = `OWRC_OFF_CYC,
  parameter int unsigned DET_CYC = `OWRC_DET_CYC,
  parameter int unsigned WIN_CYC = `OWRC_WIN_CYC,
  parameter int unsigned BITMAX_CYC = `OWRC_BITMAX_CYC,
  parameter int unsigned ACKN_CYC = `OWRC_ACKN_CYC,
  // Arbitrary value, not tied to any product
  parameter logic [7:0] DEV_ADDR = 8'h5a
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control pin, open drain
  input wire logic ctrl_pin,
  output logic ctrl_drive,
  output logic ctrl_drive_en,
  // Analog comparators
  input wire owrc_analog_t analog,
  // Power stage and reference
  output owrc_power_t power,
  output logic [10:0] fb_ref_mv,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  localparam int CW = 18;
  localparam logic [CW-1:0] L_STEP = CW'(STEP_CYC - 1);
  localparam logic [CW-1:0] L_HALF = CW'(HALF_CYC);
  localparam logic [CW-1:0] L_OFF = CW'(OFF_CYC);
  localparam logic [CW-1:0] L_DET = CW'(DET_CYC);
  localparam logic [CW-1:0] L_WIN = CW'(WIN_CYC);
  localparam logic [CW-1:0] L_BITMAX = CW'(BITMAX_CYC);
  localparam logic [CW-1:0] L_ACKN = CW'(ACKN_CYC);
  localparam logic [CW-1:0] L_VALACK = CW'(`OWRC_VALACK_CYC);
  localparam logic [CW-1:0] L_CMAX = '1;
  localparam logic [6:0] L_SWPER = 7'(`OWRC_SW_PER_CYC - 1);
  localparam int FS = `OWRC_FILT_SHIFT;
  localparam int FW = 11 + FS;

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic pin_lvl;
  owrc_analog_t an_s;
  logic pin_prev_ff;
  logic pin_fall;
  logic pin_rise;

  owrc_sync #(.W(6), .RST_VAL(6'h20)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({ctrl_pin, analog}),
    .sync_out({pin_lvl, an_s})
  );

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pin_prev_ff <= 1'b1;
    else
      pin_prev_ff <= pin_lvl;
  end

  assign pin_fall = pin_prev_ff && !pin_lvl;
  assign pin_rise = !pin_prev_ff && pin_lvl;

  // ----------------------------------------
  // Level timers
  // ----------------------------------------
  logic [CW-1:0] low_cnt_ff;
  logic [CW-1:0] high_cnt_ff;
  logic [CW-1:0] low_len_ff;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      low_cnt_ff <= '0;
      high_cnt_ff <= '0;
      low_len_ff <= '0;
    end
    else
    begin
      low_cnt_ff <= pin_lvl ? '0 : low_cnt_ff + CW'(low_cnt_ff != L_CMAX);
      high_cnt_ff <= !pin_lvl ? '0 : high_cnt_ff + CW'(high_cnt_ff != L_CMAX);
      if (pin_rise)
        low_len_ff <= low_cnt_ff;
    end
  end

  // ----------------------------------------
  // Control register and protection
  // ----------------------------------------
  logic [1:0] ctrl_ff;
  logic therm_ff;
  logic lock;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ctrl_ff <= `OWRC_CTRL_RST;
    else if (reg_wr && reg_addr == `OWRC_REG_CTRL)
      ctrl_ff <= reg_wdata[1:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      therm_ff <= 1'b0;
    else if (an_s.over_temp)
      therm_ff <= 1'b1;
    else if (an_s.temp_cooled)
      therm_ff <= 1'b0;
  end

  assign lock = an_s.supply_lockout || therm_ff || ctrl_ff[`OWRC_CTRL_FORCE_OFF];

  // ----------------------------------------
  // Device state
  // ----------------------------------------
  owrc_state_t state_ff;
  owrc_state_t nxt_state;
  logic [5:0] ramp_step_ff;
  logic [CW-1:0] ramp_cnt_ff;
  logic go_off;

  assign go_off = lock || low_cnt_ff > L_OFF;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      OWRC_ST_OFF:
        if (!lock && pin_lvl)
          nxt_state = OWRC_ST_START;
      OWRC_ST_START:
        if (go_off)
          nxt_state = OWRC_ST_OFF;
        else if (ramp_step_ff == `OWRC_RAMP_STEPS)
          nxt_state = OWRC_ST_RUN;
      OWRC_ST_RUN:
        if (go_off)
          nxt_state = OWRC_ST_OFF;
      default:
        nxt_state = OWRC_ST_OFF;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_ff <= OWRC_ST_OFF;
    else
      state_ff <= nxt_state;
  end

  // ----------------------------------------
  // Soft start ramp and half limit
  // ----------------------------------------
  logic [CW-1:0] half_cnt_ff;
  logic half_ff;

  always_ff @(posedge sys_clk)
  begin
    if (rst || state_ff == OWRC_ST_OFF)
    begin
      ramp_step_ff <= '0;
      ramp_cnt_ff <= '0;
    end
    else if (ramp_step_ff != `OWRC_RAMP_STEPS)
    begin
      if (ramp_cnt_ff == L_STEP)
      begin
        ramp_cnt_ff <= '0;
        ramp_step_ff <= ramp_step_ff + 6'h01;
      end
      else
        ramp_cnt_ff <= ramp_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || nxt_state == OWRC_ST_OFF)
    begin
      half_cnt_ff <= '0;
      half_ff <= 1'b0;
    end
    else
    begin
      if (half_cnt_ff != L_HALF)
        half_cnt_ff <= half_cnt_ff + 1'b1;
      half_ff <= half_cnt_ff < L_HALF;
    end
  end

  // ----------------------------------------
  // Switch gating
  // ----------------------------------------
  logic [6:0] sw_cnt_ff;
  logic sw_gate_ff;
  logic cyc_start;
  logic trip;

  assign cyc_start = sw_cnt_ff == 7'h00;
  assign trip = an_s.current_trip || an_s.overcurrent;

  always_ff @(posedge sys_clk)
  begin
    if (rst || sw_cnt_ff == L_SWPER)
      sw_cnt_ff <= '0;
    else
      sw_cnt_ff <= sw_cnt_ff + 7'h01;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || lock || state_ff == OWRC_ST_OFF)
      sw_gate_ff <= 1'b0;
    else if (trip)
      sw_gate_ff <= 1'b0;
    else if (cyc_start)
      sw_gate_ff <= 1'b1;
  end

  assign power.sw_gate = sw_gate_ff;
  assign power.half_limit = half_ff;

  // ----------------------------------------
  // Mode selection
  // ----------------------------------------
  owrc_mode_t mode_ff;
  logic [CW-1:0] win_cnt_ff;

  always_ff @(posedge sys_clk)
  begin
    if (rst || state_ff == OWRC_ST_OFF)
    begin
      mode_ff <= OWRC_MD_PWM;
      win_cnt_ff <= '0;
    end
    else
    begin
      if (win_cnt_ff != L_WIN)
        win_cnt_ff <= win_cnt_ff + 1'b1;
      if (win_cnt_ff != L_WIN && low_cnt_ff > L_DET && ctrl_ff[`OWRC_CTRL_WIRE_EN])
        mode_ff <= OWRC_MD_WIRE;
    end
  end

  // ----------------------------------------
  // PWM reference filter
  // ----------------------------------------
  logic [FW-1:0] filt_ff;
  logic [10:0] chop;

  assign chop = pin_lvl ? `OWRC_REF_FULL_MV : 11'h000;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      filt_ff <= '0;
    else
      filt_ff <= filt_ff - (filt_ff >> FS) + FW'(chop);
  end

  // ----------------------------------------
  // One-wire receiver
  // ----------------------------------------
  logic rx_act;
  logic byte_open_ff;
  logic [4:0] bits_ff;
  logic [15:0] shift_ff;
  logic bit_one;
  logic bit_zero;
  logic [15:0] frame;
  logic rx_timeout;
  logic frame_done;
  logic frame_ok;
  logic frame_bad;
  logic [4:0] level_ff;
  logic ack_req_ff;
  logic ack_wait_ff;
  logic ack_on_ff;
  logic [CW-1:0] ack_cnt_ff;

  assign rx_act = mode_ff == OWRC_MD_WIRE && state_ff != OWRC_ST_OFF
    && !ack_wait_ff && !ack_on_ff;
  assign bit_one = {1'b0, high_cnt_ff} >= {low_len_ff, 1'b0};
  assign bit_zero = {1'b0, low_len_ff} >= {high_cnt_ff, 1'b0};
  assign frame = {shift_ff[14:0], bit_one};
  assign rx_timeout = (byte_open_ff || bits_ff != 5'h00)
    && (low_cnt_ff > L_BITMAX || high_cnt_ff > L_BITMAX);
  assign frame_done = rx_act && pin_fall && byte_open_ff && (bit_one || bit_zero)
    && bits_ff == `OWRC_FRAME_BITS - 5'h01;
  assign frame_ok = frame_done && frame[15:8] == DEV_ADDR
    && frame[6:5] == `OWRC_SUB_ADDR;
  assign frame_bad = (frame_done && !frame_ok)
    || (rx_act && pin_fall && byte_open_ff && !bit_one && !bit_zero)
    || (rx_act && rx_timeout);

  always_ff @(posedge sys_clk)
  begin
    if (rst || !rx_act || frame_bad || frame_done)
    begin
      byte_open_ff <= 1'b0;
      bits_ff <= '0;
      shift_ff <= '0;
    end
    else if (pin_fall)
    begin
      if (!byte_open_ff)
        byte_open_ff <= 1'b1;
      else
      begin
        shift_ff <= frame;
        bits_ff <= bits_ff + 5'h01;
        if (bits_ff[2:0] == 3'h7)
          byte_open_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      level_ff <= `OWRC_LEVEL_RST;
    else if (frame_ok)
      level_ff <= frame[4:0];
  end

  // ----------------------------------------
  // Acknowledge
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst || state_ff == OWRC_ST_OFF)
    begin
      ack_req_ff <= 1'b0;
      ack_wait_ff <= 1'b0;
      ack_on_ff <= 1'b0;
      ack_cnt_ff <= '0;
    end
    else if (frame_ok)
    begin
      ack_req_ff <= frame[7];
      ack_wait_ff <= frame[7];
      ack_cnt_ff <= '0;
    end
    else if (ack_wait_ff)
    begin
      ack_cnt_ff <= ack_cnt_ff + 1'b1;
      if (ack_cnt_ff == L_VALACK - 1'b1)
      begin
        ack_wait_ff <= 1'b0;
        ack_on_ff <= 1'b1;
        ack_cnt_ff <= '0;
      end
    end
    else if (ack_on_ff)
    begin
      ack_cnt_ff <= ack_cnt_ff + 1'b1;
      if (ack_cnt_ff == L_ACKN - 1'b1)
      begin
        ack_on_ff <= 1'b0;
        ack_req_ff <= 1'b0;
      end
    end
  end

  assign ctrl_drive = 1'b0;
  assign ctrl_drive_en = ack_on_ff;

  // ----------------------------------------
  // Reference output
  // ----------------------------------------
  logic [10:0] rom_mv;
  logic [10:0] target;
  logic [16:0] scaled;

  owrc_level_rom u_rom (
    .sys_clk(sys_clk),
    .code(level_ff),
    .ref_mv(rom_mv)
  );

  assign target = mode_ff == OWRC_MD_WIRE ? rom_mv : filt_ff[FW-1:FS];
  assign scaled = target * ramp_step_ff;

  always_ff @(posedge sys_clk)
  begin
    if (rst || state_ff == OWRC_ST_OFF)
      fb_ref_mv <= '0;
    else
      fb_ref_mv <= scaled[15:5];
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst || !reg_rd)
      reg_rdata <= '0;
    else
      unique case (reg_addr)
        `OWRC_REG_CTRL:
          reg_rdata <= {30'h0, ctrl_ff};
        `OWRC_REG_STATUS:
          reg_rdata <= {24'h0, ack_on_ff, therm_ff, lock, half_ff,
            sw_gate_ff, mode_ff, state_ff};
        `OWRC_REG_LEVEL:
          reg_rdata <= {5'h0, fb_ref_mv, 11'h0, level_ff};
        default:
          reg_rdata <= '0;
      endcase
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_lockout_off;
    an_s.supply_lockout |=> !sw_gate_ff && state_ff == OWRC_ST_OFF;
  endproperty
  a_lockout_off: assert property (p_lockout_off) else $error("switch on in lockout");

  property p_therm_off;
    $rose(therm_ff) |=> !sw_gate_ff && state_ff == OWRC_ST_OFF;
  endproperty
  a_therm_off: assert property (p_therm_off) else $error("running while hot");

  property p_trip_ends;
    sw_gate_ff && trip |=> !sw_gate_ff;
  endproperty
  a_trip_ends: assert property (p_trip_ends) else $error("trip ignored");

  property p_cycle_on;
    state_ff == OWRC_ST_RUN && cyc_start && !lock && !trip |=> sw_gate_ff;
  endproperty
  a_cycle_on: assert property (p_cycle_on) else $error("no turn-on at cycle start");

  property p_long_low;
    state_ff != OWRC_ST_OFF && low_cnt_ff > L_OFF |=> state_ff == OWRC_ST_OFF;
  endproperty
  a_long_low: assert property (p_long_low) else $error("long low missed");

  property p_ramp_step;
    state_ff == OWRC_ST_START && !go_off && ramp_cnt_ff == L_STEP
      |=> ramp_step_ff == $past(ramp_step_ff) + 6'h01;
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp step wrong");

  property p_half_start;
    state_ff == OWRC_ST_OFF && nxt_state == OWRC_ST_START |=> ##1 half_ff;
  endproperty
  a_half_start: assert property (p_half_start) else $error("no half limit");

  property p_ack_len;
    ack_on_ff |-> ack_cnt_ff < L_ACKN;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack too long");

  property p_ack_req;
    $rose(ack_on_ff) |-> ack_req_ff && $past(ack_wait_ff);
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("unrequested ack");

  property p_bad_keep;
    frame_bad |=> level_ff == $past(level_ff) && !ack_wait_ff;
  endproperty
  a_bad_keep: assert property (p_bad_keep) else $error("bad frame changed level");
endmodule

//--- core/owrc_level_rom.sv
// Purpose: level code to reference millivolt table
// Assumes: one cycle read latency
// Notes: steps coarser at the top codes
`timescale 1ns/100ps
module owrc_level_rom (
  // Clock
  input wire logic sys_clk,
  // Lookup
  input wire logic [4:0] code,
  output logic [10:0] ref_mv
);
  localparam logic [10:0] TABLE [32] = '{
    11'h000, 11'h01f, 11'h031, 11'h044, 11'h056, 11'h068, 11'h07b, 11'h08d,
    11'h0a0, 11'h0b2, 11'h0c5, 11'h0d7, 11'h0ea, 11'h10e, 11'h133, 11'h158,
    11'h17d, 11'h1a2, 11'h1c7, 11'h1ec, 11'h210, 11'h235, 11'h25a, 11'h27f,
    11'h2c9, 11'h313, 11'h35c, 11'h3a6, 11'h3f0, 11'h43a, 11'h483, 11'h4cd
  };

  always_ff @(posedge sys_clk)
  begin
    ref_mv <= TABLE[code];
  end
endmodule

//--- core/owrc_map.svh
// Purpose: constants for the one-wire reference control block
// Assumes: 50 MHz system clock
// Notes on behaviour
// - Ramp reference up in 32 steps, 213 us each
// - Half current limit for first 5 ms
// - Switch on each 1.2 MHz cycle start, off at threshold
// - Overcurrent ends cycle; re-arm next cycle
// - Supply lockout keeps device and switch off
// - Thermal shutdown above 160 C, restart after 15 C drop
// - Pin low over 2.5 ms means shutdown
// - Constant high pin gives full 1.229 V reference
// - PWM mode: filtered duty times 1.229 V
// - One command picks one of 32 stored levels
// - Level defaults to code 31 after power reset
// - Command is address byte then data byte
// - Data byte: ack request, sub-address, level code
// - Acknowledge only if requested and frame correct
// - Bits decoded by ratio, 1.7 to 160 kbit/s
// - Level code maps monotonically to reference table
// - Falling to falling bit; 2x ratio decides value
// - MSB first; bit 7 ack, 6:5 sub, 4:0 code
// - Ack pulls line low at most 512 us after delay
// - One-wire mode after low over 260 us in window
`ifndef OWRC_MAP_SVH
`define OWRC_MAP_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define OWRC_CLK_MHZ 50
`define OWRC_T_STEP_US 213
`define OWRC_STEP_CYC (`OWRC_T_STEP_US * `OWRC_CLK_MHZ)
`define OWRC_T_HALF_MS 5
`define OWRC_HALF_CYC (`OWRC_T_HALF_MS * 1000 * `OWRC_CLK_MHZ)
`define OWRC_T_OFF_MS 2.5
`define OWRC_OFF_CYC ($rtoi(`OWRC_T_OFF_MS * 1000.0 * `OWRC_CLK_MHZ))
`define OWRC_T_DET_US 260
`define OWRC_DET_CYC (`OWRC_T_DET_US * `OWRC_CLK_MHZ)
`define OWRC_T_WIN_MS 1
`define OWRC_WIN_CYC (`OWRC_T_WIN_MS * 1000 * `OWRC_CLK_MHZ)
`define OWRC_T_BITMAX_US 360
`define OWRC_BITMAX_CYC (`OWRC_T_BITMAX_US * `OWRC_CLK_MHZ)
`define OWRC_T_ACKN_US 512
`define OWRC_ACKN_CYC (`OWRC_T_ACKN_US * `OWRC_CLK_MHZ)
`define OWRC_T_VALACK_US 2
`define OWRC_VALACK_CYC (`OWRC_T_VALACK_US * `OWRC_CLK_MHZ)
`define OWRC_SW_KHZ 1200
`define OWRC_SW_PER_CYC (`OWRC_CLK_MHZ * 1000 / `OWRC_SW_KHZ)

// ----------------------------------------
// Reference and frame
// ----------------------------------------
`define OWRC_RAMP_STEPS 6'h20
`define OWRC_REF_FULL_MV 11'h4cd
`define OWRC_LEVEL_RST 5'h1f
`define OWRC_SUB_ADDR 2'h0
`define OWRC_FRAME_BITS 5'h10
`define OWRC_FILT_SHIFT 13

// ----------------------------------------
// Register port
// ----------------------------------------
`define OWRC_REG_CTRL 4'h0
`define OWRC_REG_STATUS 4'h4
`define OWRC_REG_LEVEL 4'h8
`define OWRC_CTRL_RST 2'h1
`define OWRC_CTRL_WIRE_EN 0
`define OWRC_CTRL_FORCE_OFF 1

`endif

//--- core/owrc_pkg.sv
// Purpose: shared types of the one-wire reference control block
// Assumes: nothing
// Notes: constants live in owrc_map.svh
package owrc_pkg;
  typedef enum logic [1:0] {
    OWRC_ST_OFF = 2'b00,
    OWRC_ST_START = 2'b01,
    OWRC_ST_RUN = 2'b10
  } owrc_state_t;
  typedef enum logic {
    OWRC_MD_PWM = 1'b0,
    OWRC_MD_WIRE = 1'b1
  } owrc_mode_t;
  typedef struct packed {
    logic supply_lockout;
    logic over_temp;
    logic temp_cooled;
    logic current_trip;
    logic overcurrent;
  } owrc_analog_t;
  typedef struct packed {
    logic sw_gate;
    logic half_limit;
  } owrc_power_t;
endpackage

//--- core/owrc_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs asynchronous to sys_clk
// Notes: output changes once stages two and three agree
`timescale 1ns/100ps
module owrc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge sys_clk)
      begin
        if (rst)
        begin
          s1_ff[i] <= RST_VAL[i];
          s2_ff[i] <= RST_VAL[i];
          s3_ff[i] <= RST_VAL[i];
          sync_out[i] <= RST_VAL[i];
        end
        else
        begin
          s1_ff[i] <= async_in[i];
          s2_ff[i] <= s1_ff[i];
          s3_ff[i] <= s2_ff[i];
          if (s2_ff[i] == s3_ff[i])
            sync_out[i] <= s3_ff[i];
        end
      end
    end
  endgenerate
endmodule

//--- verification/owrc_host.sv
// Purpose: host model that drives the control pin
// Assumes: the line is pulled up whenever it is released
// Notes: bit length is set per call by a unit in clocks
`timescale 1ns/100ps
module owrc_host (
  // Clock
  input wire logic sys_clk,
  // Pin release, 1 lets the pull-up win
  output logic host_rel
);
  // ----------------------------------------
  // Pin sequences
  // ----------------------------------------
  initial host_rel = 1'b1;

  task automatic hold(input logic l, input int n);
    @(posedge sys_clk);
    host_rel <= l;
    repeat (n - 1) @(posedge sys_clk);
  endtask

  // A 3:1 split keeps a margin over the 2x ratio at any unit from 2 clocks to a third of the bit timeout
  task automatic send_byte(input logic [7:0] b, input int u);
    for (int i = 7; i >= 0; i--)
    begin
      hold(1'b0, b[i] ? u : 3 * u);  // MSB first
      hold(1'b1, b[i] ? 3 * u : u);
    end
    hold(1'b0, 20);  // Closing edge, then end of stream
  endtask

  // Start condition before each byte, address byte first
  task automatic frame(input logic [7:0] a, input logic [7:0] d, input int u);
    hold(1'b1, 20);
    send_byte(a, u);
    hold(1'b1, 20);
    send_byte(d, u);
    hold(1'b1, 1);
  endtask
endmodule

//--- verification/tb_owrc_core.sv
// Purpose: self-checking bench for owrc_core
// Assumes: shortened timing parameters set below
// Notes: host model drives the pin, the bench the flags and registers
`timescale 1ns/100ps
module tb_owrc_core;
  import owrc_pkg::*;
  // Arbitrary address value, same as the design default
  localparam logic [7:0] DEV = 8'h5a;
  localparam int MV [32] = '{0, 31, 49, 68, 86, 104, 123, 141, 160, 178, 197, 215,
    234, 270, 307, 344, 381, 418, 455, 492, 528, 565, 602, 639, 713, 787, 860, 934,
    1008, 1082, 1155, 1229};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ctrl_pin;
  logic ctrl_drive;
  logic ctrl_drive_en;
  logic host_rel;
  owrc_analog_t an = '0;
  owrc_power_t power;
  logic [10:0] fb_ref_mv;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] d;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #10 sys_clk = ~sys_clk;
  // Open-drain wire with pull-up
  assign ctrl_pin = host_rel & ~(ctrl_drive_en & ~ctrl_drive);

  owrc_host host (.sys_clk(sys_clk), .host_rel(host_rel));
  owrc_core #(.STEP_CYC(20), .HALF_CYC(200), .OFF_CYC(400), .DET_CYC(40),
    .ACKN_CYC(30)) dut (
    .sys_clk(sys_clk), .rst(rst), .ctrl_pin(ctrl_pin), .ctrl_drive(ctrl_drive),
    .ctrl_drive_en(ctrl_drive_en), .analog(an), .power(power), .fb_ref_mv(fb_ref_mv),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask

  task automatic st(input logic [31:0] m, input logic [31:0] e);
    rd(4'h4);
    chk(d & m, e);
  endtask

  task automatic at(input int n);
    while (cyc < n) @(posedge sys_clk);
  endtask

  task automatic wg(input logic v, input int n);
    int k;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (power.sw_gate !== v && k < n);
    chk(power.sw_gate, v);
  endtask

  task automatic fchk(input logic [7:0] a, input logic [7:0] dd, input int u,
    input logic [4:0] ec, input int ea);
    int n;
    n = 0;
    host.frame(a, dd, u);
    repeat (200)
    begin
      @(posedge sys_clk);
      n += (ctrl_drive_en === 1'b1);
    end
    chk(n, ea);
    rd(4'h8);
    chk(d & 32'h07ff001f, {5'h0, 11'(MV[ec]), 11'h0, ec});
  endtask

  always @(posedge sys_clk)
  begin
    cyc <= rst ? 0 : cyc + 1;
    if (cyc == 90000)
    begin
      n_fail++;
      tally_and_finish;
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(4'h0);
    chk(d, 32'h1);
    rd(4'hc);
    chk(d, 32'h0);
    rd(4'h8);
    chk(d[4:0], 5'h1f);
    chk(power.half_limit, 1'b1);
    host.hold(1'b0, 60);
    host.hold(1'b1, 10);
    at(320);
    chk(fb_ref_mv >= 11'd576 && fb_ref_mv <= 11'd652, 1'b1);
    at(600);
    st(32'h3, 32'h1);
    at(680);
    st(32'h17, 32'h6);
    chk(fb_ref_mv, 11'd1229);
    wg(1'b1, 45);
    for (int i = 0; i < 2; i++)
    begin
      an.current_trip <= (i == 0);
      an.overcurrent <= (i == 1);
      wg(1'b0, 8);
      repeat (100) @(posedge sys_clk);
      chk(power.sw_gate, 1'b0);
      an <= '0;
      wg(1'b1, 50);
    end
    for (int c = 0; c < 32; c++)
      fchk(DEV, {c[0], 2'b00, 5'(c)}, c[0] ? 4 : 20, 5'(c), c[0] ? 30 : 0);
    fchk(DEV ^ 8'h01, 8'h85, 6, 5'h1f, 0);
    fchk(DEV, 8'ha5, 6, 5'h1f, 0);
    host.hold(1'b1, 20);
    host.send_byte(DEV, 6);
    host.hold(1'b1, 18100);  // Idle past the frame timeout
    rd(4'h8);
    chk(d[4:0], 5'h1f);
    fchk(DEV, 8'h85, 6, 5'h05, 30);  // Aborted frame left no stale bits
    an.supply_lockout <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk(power.sw_gate, 1'b0);
    st(32'h3, 32'h0);
    an <= '0;
    repeat (10) @(posedge sys_clk);
    st(32'h3, 32'h1);
    an.over_temp <= 1'b1;
    repeat (10) @(posedge sys_clk);
    an <= '0;
    repeat (10) @(posedge sys_clk);
    st(32'h43, 32'h40);
    an.temp_cooled <= 1'b1;
    repeat (10) @(posedge sys_clk);
    an <= '0;
    repeat (10) @(posedge sys_clk);
    st(32'h43, 32'h1);
    host.hold(1'b0, 450);
    st(32'h3, 32'h0);
    host.hold(1'b1, 200);
    st(32'h7, 32'h1);
    wr(4'h0, 32'h3);
    repeat (5) @(posedge sys_clk);
    st(32'h3, 32'h0);
    wr(4'h0, 32'h1);
    repeat (5) @(posedge sys_clk);
    st(32'h3, 32'h1);
    // Half duty; lows stay under the detection time
    repeat (500)
    begin
      host.hold(1'b0, 20);
      host.hold(1'b1, 20);
    end
    chk(fb_ref_mv >= 11'h258 && fb_ref_mv <= 11'h2a8, 1'b1);
    st(32'h7, 32'h2);
    tally_and_finish;
  end
endmodule
